// ### bcd_unit.sv
// Packed decimal add, subtract, negate, decimal_a and unpack
`timescale 1ns/1ps
`default_nettype none
module bcd_unit
(
   input wire exec_pkg::bcd_req_t req,
   output exec_pkg::bcd_resp_t resp
);
   import exec_pkg::*;

   function automatic logic [8:0] dec_add(input logic [7:0] a,
      input logic [7:0] b, input logic cin);
      logic [4:0] lo;
      logic [4:0] hi;
      logic lc;
      logic hc;
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      lc = lo > DIGIT_MAX;
      if (lc)
      begin
         lo = lo + DIGIT_ADJ;
      end
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lc};
      hc = hi > DIGIT_MAX;
      if (hc)
      begin
         hi = hi + DIGIT_ADJ;
      end
      dec_add = {hc, hi[3:0], lo[3:0]};
   endfunction : dec_add

   // Borrow out of each digit comes from bit 4 of the 5-bit difference
   function automatic logic [8:0] dec_sub(input logic [7:0] a,
      input logic [7:0] b, input logic bin);
      logic [4:0] lo;
      logic [4:0] hi;
      logic lb;
      logic hb;
      lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
      lb = lo[4];
      if (lb)
      begin
         lo = lo - DIGIT_ADJ;
      end
      hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lb};
      hb = hi[4];
      if (hb)
      begin
         hi = hi - DIGIT_ADJ;
      end
      dec_sub = {hb, hi[3:0], lo[3:0]};
   endfunction : dec_sub

   logic [8:0] r9;
   logic [15:0] t16;

   always_comb
   begin
      r9 = 9'h000;
      t16 = 16'h0000;
      resp = '0;
      case (req.op)
         decimal_add_extend:
         begin
            r9 = dec_add(req.dst, req.src, req.x);
            resp = {8'h00, r9[7:0], r9[8]};
         end
         decimal_sub_extend:
         begin
            r9 = dec_sub(req.dst, req.src, req.x);
            resp = {8'h00, r9[7:0], r9[8]};
         end
         decimal_negate_extend:
         begin
            r9 = dec_sub(8'h00, req.dst, req.x);
            resp = {8'h00, r9[7:0], r9[8]};
         end
         decimal_a:
         begin
            t16 = req.wide + req.adj;
            resp = {8'h00, t16[11:8], t16[3:0], 1'b0};
         end
         decimal_unpack:
         begin
            t16 = {4'h0, req.src[7:4], 4'h0, req.src[3:0]};
            resp = {t16 + req.adj, 1'b0};
         end
         default:
         begin
            resp = '0;
         end
      endcase
   end
endmodule : bcd_unit
`default_nettype wire

// ### bit_field_bcd_execution_unit.sv
// Bit, bit-field and decimal execution unit behind an AXI4-Lite slave
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module bit_field_bcd_execution_unit
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [exec_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [exec_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp
);
   import exec_pkg::*;

   state_t s_q;
   state_t s_d;

   op_t op;
   logic mem_dest;
   logic [31:0] idx_src;
   logic [4:0] bit_n;
   logic [31:0] dst_w;
   logic bit_old;
   logic [31:0] one_hot;
   logic [4:0] ofs;
   logic [5:0] wid;
   logic [31:0] rot;
   logic [31:0] mask;
   logic [31:0] low_mask;
   logic [31:0] fval;
   logic [31:0] ins;
   logic [31:0] new_rot;
   logic [31:0] new_dst;
   logic [5:0] lead;
   logic [31:0] ffo;
   bcd_req_t bcd_req;
   bcd_resp_t bcd_resp;
   logic [31:0] result;
   logic [4:0] flags;
   logic [32:0] rd_word;

   function automatic logic [31:0] rotl(input logic [31:0] v,
      input logic [4:0] n);
      logic [63:0] t;
      t = {v, v} << n;
      rotl = t[63:32];
   endfunction : rotl

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      merge = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction : merge

   // Bit 32 flags a mapped address
   function automatic logic [32:0] read_word(input state_t s,
      input logic [7:0] a);
      case ({a[7:2], 2'b00})
         ADDR_OP: read_word = {1'b1, s.op_reg};
         ADDR_DST: read_word = {1'b1, s.dst_reg};
         ADDR_SRC: read_word = {1'b1, s.src_reg};
         ADDR_IMM: read_word = {1'b1, s.imm_reg};
         ADDR_FIELD: read_word = {1'b1, s.fld_reg};
         ADDR_GO: read_word = {1'b1, 31'h0000_0000, s.go};
         ADDR_RESULT: read_word = {1'b1, s.result_reg};
         ADDR_FLAGS: read_word = {1'b1, 27'h000_0000, s.flags_reg};
         default: read_word = {1'b0, 32'h0000_0000};
      endcase
   endfunction : read_word

   // Operand decode
   always_comb
   begin
      op = op_t'(s_q.op_reg[OP_CODE_LSB +: 5]);
      mem_dest = s_q.op_reg[OP_MEM_BIT];
      // Index source: data register or immediate extension
      idx_src = s_q.op_reg[OP_IDX_REG_BIT] ? s_q.src_reg
         : s_q.imm_reg;
      bit_n = mem_dest ? {2'b00, idx_src[2:0]} : idx_src[4:0];
      dst_w = mem_dest ? {24'h00_0000, s_q.dst_reg[7:0]}
         : s_q.dst_reg;
      bit_old = dst_w[bit_n];
      one_hot = 32'h0000_0001 << bit_n;
   end

   // Field image rotated so the field's msb sits at bit 31
   always_comb
   begin
      ofs = s_q.fld_reg[FLD_OFS_LSB +: 5];
      // Width code zero stands for a full 32-bit field
      wid = (s_q.fld_reg[FLD_WID_LSB +: 5] == 5'h00) ? FULL_WIDTH
         : {1'b0, s_q.fld_reg[FLD_WID_LSB +: 5]};
      rot = rotl(s_q.dst_reg, ofs);
      low_mask = 32'hffff_ffff >> (FULL_WIDTH - wid);
      mask = ~(32'hffff_ffff >> wid);
      fval = rot >> (FULL_WIDTH - wid);
      ins = s_q.src_reg << (FULL_WIDTH - wid);
      case (op)
         field_test_set: new_rot = rot | mask;
         field_test_clear: new_rot = rot & ~mask;
         field_test_invert: new_rot = rot ^ mask;
         field_insert: new_rot = (rot & ~mask) | (ins & mask);
         default: new_rot = rot;
      endcase
      // Rotating back by the negated offset restores field position
      new_dst = rotl(new_rot, 5'h00 - ofs);
      if (lead < wid)
      begin
         ffo = {27'h000_0000, ofs} + {26'h000_0000, lead};
      end
      else
      begin
         ffo = {27'h000_0000, ofs} + {26'h000_0000, wid};
      end
   end

   field_scan u_scan
   (
      .bits(rot & mask),
      .lead_zeros(lead)
   );

   always_comb
   begin
      bcd_req.op = op;
      bcd_req.x = s_q.flags_reg[FLAG_X];
      bcd_req.dst = s_q.dst_reg[7:0];
      bcd_req.src = s_q.src_reg[7:0];
      bcd_req.wide = s_q.src_reg[15:0];
      bcd_req.adj = s_q.imm_reg[15:0];
   end

   bcd_unit u_bcd
   (
      .req(bcd_req),
      .resp(bcd_resp)
   );

   // Result and flags of the pending operation
   always_comb
   begin
      result = s_q.dst_reg;
      flags = s_q.flags_reg;
      case (op)
         single_bit_test:
         begin
            flags[FLAG_Z] = ~bit_old;
            result = dst_w;
         end
         single_bit_test_set:
         begin
            flags[FLAG_Z] = ~bit_old;
            result = dst_w | one_hot;
         end
         single_bit_test_clear:
         begin
            flags[FLAG_Z] = ~bit_old;
            result = dst_w & ~one_hot;
         end
         single_bit_test_invert:
         begin
            flags[FLAG_Z] = ~bit_old;
            result = dst_w ^ one_hot;
         end
         field_test, field_test_set, field_test_clear, field_test_invert,
         field_insert, field_extract_zero_ext, field_extract_sign_ext,
         field_find_first_one:
         begin
            // Flags come from the field before it is modified
            flags[FLAG_N] = rot[31];
            flags[FLAG_Z] = ~|(rot & mask);
            flags[FLAG_V] = 1'b0;
            flags[FLAG_C] = 1'b0;
            case (op)
               field_extract_zero_ext: result = fval;
               field_extract_sign_ext:
                  result = fval | (rot[31] ? ~low_mask
                     : 32'h0000_0000);
               field_find_first_one: result = ffo;
               default: result = new_dst;
            endcase
         end
         decimal_add_extend, decimal_sub_extend, decimal_negate_extend:
         begin
            result = {s_q.dst_reg[31:8], bcd_resp.value[7:0]};
            flags[FLAG_C] = bcd_resp.carry;
            flags[FLAG_X] = bcd_resp.carry;
            // Zero only clears, so multi-byte chains test the whole string
            if (bcd_resp.value[7:0] != 8'h00)
            begin
               flags[FLAG_Z] = 1'b0;
            end
         end
         decimal_a:
         begin
            result = {s_q.dst_reg[31:8], bcd_resp.value[7:0]};
         end
         decimal_unpack:
         begin
            result = {s_q.dst_reg[31:16], bcd_resp.value};
         end
         default:
         begin
            result = s_q.dst_reg;
         end
      endcase
   end

   // Reads wait while an operation is pending, so results are never stale
   always_comb
   begin
      awready = !s_q.aw_have && !s_q.bvalid;
      wready = !s_q.w_have && !s_q.bvalid;
      arready = !s_q.rvalid && !s_q.go;
      bvalid = s_q.bvalid;
      bresp = s_q.bresp;
      rvalid = s_q.rvalid;
      rdata = s_q.rdata;
      rresp = s_q.rresp;
      rd_word = read_word(s_q, araddr);
   end

   always_comb
   begin
      s_d = s_q;
      if (awvalid && awready)
      begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = awaddr;
      end
      if (wvalid && wready)
      begin
         s_d.w_have = 1'b1;
         s_d.w_data = wdata;
         s_d.w_strb = wstrb;
      end
      if (s_q.bvalid && bready)
      begin
         s_d.bvalid = 1'b0;
      end
      // Commit one cycle after both halves are held
      if (s_q.aw_have && s_q.w_have)
      begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = RESP_OKAY;
         case ({s_q.aw_addr[7:2], 2'b00})
            ADDR_OP: s_d.op_reg = merge(s_q.op_reg, s_q.w_data, s_q.w_strb);
            ADDR_DST:
               s_d.dst_reg = merge(s_q.dst_reg, s_q.w_data, s_q.w_strb);
            ADDR_SRC:
               s_d.src_reg = merge(s_q.src_reg, s_q.w_data, s_q.w_strb);
            ADDR_IMM:
               s_d.imm_reg = merge(s_q.imm_reg, s_q.w_data, s_q.w_strb);
            ADDR_FIELD:
               s_d.fld_reg = merge(s_q.fld_reg, s_q.w_data, s_q.w_strb);
            ADDR_FLAGS:
            begin
               if (s_q.w_strb[0])
               begin
                  s_d.flags_reg = s_q.w_data[4:0];
               end
            end
            ADDR_GO: s_d.go = 1'b1;
            ADDR_RESULT: s_d.bresp = RESP_OKAY;
            default: s_d.bresp = RESP_SLVERR;
         endcase
      end
      // Execution after the bus write, so hardware flags win a collision
      if (s_q.go)
      begin
         s_d.go = 1'b0;
         s_d.result_reg = result;
         s_d.flags_reg = flags;
      end
      if (s_q.rvalid && rready)
      begin
         s_d.rvalid = 1'b0;
      end
      if (arvalid && arready)
      begin
         s_d.rvalid = 1'b1;
         s_d.rdata = rd_word[31:0];
         s_d.rresp = rd_word[32] ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q <= STATE_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule : bit_field_bcd_execution_unit
`default_nettype wire

// ### bit_field_bcd_execution_unit_tb.sv
// Self-checking bench for the bit, field and decimal execution unit
`timescale 1ns/1ps
`default_nettype none
module bit_field_bcd_execution_unit_tb;
   import exec_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata, got;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp, md;
   int n_fail = 0;
   int n_checks = 0;

   bit_field_bcd_execution_unit dut
   (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp)
   );
   exec_master m
   (
      .aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp)
   );

   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // Run needs under 1000 cycles; 25000 leaves room for slow answers
   initial
   begin
      #200000;
      n_fail++;
      wrap_up();
   end

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] seen);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Aux goes to both immediate and field registers; each op reads at most one
   task automatic xc(input op_t op, input logic [31:0] dst,
      input logic [31:0] src, input logic [15:0] aux, input logic [4:0] fl,
      input logic [31:0] er, input logic [4:0] ef);
      m.wr(ADDR_OP, {22'h0, md, 3'h0, op}, resp);
      m.wr(ADDR_DST, dst, resp);
      m.wr(ADDR_SRC, src, resp);
      m.wr(ADDR_IMM, {16'h0, aux}, resp);
      m.wr(ADDR_FIELD, {16'h0, aux}, resp);
      m.wr(ADDR_FLAGS, {27'h0, fl}, resp);
      m.wr(ADDR_GO, 32'h1, resp);
      m.rd(ADDR_RESULT, got, resp);
      chk("result", er, got);
      m.rd(ADDR_FLAGS, got, resp);
      chk("flags", {27'h0, ef}, got);
   endtask : xc

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   initial
   begin
      aresetn = 1'b0;
      md = 2'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int a = 0; a < 32; a += 4)
      begin
         m.rd(8'(a), got, resp);
         chk("reset value", 32'h0, got);
      end
      m.rd(8'h40, got, resp);
      chk("hole rdata", 32'h0, got);
      chk("hole rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      m.wr(8'h44, 32'h1, resp);
      chk("hole bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      xc(single_bit_test, 32'h20,
         32'h0, 16'h5, 5'h04, 32'h20, 5'h00);
      xc(single_bit_test_invert, 32'h0,
         32'h0, 16'h1f, 5'h1b, 32'h80000000, 5'h1f);
      md = 2'h2;
      xc(single_bit_test_set, 32'h0,
         32'h21, 16'h0, 5'h00, 32'h2, 5'h04);
      // Memory byte with a register index of 9 must select bit 1
      md = 2'h3;
      xc(single_bit_test_clear, 32'hffffff02,
         32'h9, 16'h0, 5'h04, 32'h0, 5'h00);
      md = 2'h0;
      xc(field_test, 32'hf0000000,
         32'h0, 16'h0400, 5'h17, 32'hf0000000, 5'h18);
      xc(field_test_set, 32'h0,
         32'h0, 16'h0804, 5'h00, 32'h0ff00000, 5'h04);
      xc(field_test_clear, 32'hffffffff,
         32'h0, 16'h081c, 5'h00, 32'h0ffffff0, 5'h08);
      xc(field_test_invert, 32'ha5,
         32'h0, 16'h0818, 5'h10, 32'h5a, 5'h18);
      xc(field_extract_sign_ext, 32'hc00,
         32'h0, 16'h0414, 5'h00, 32'hfffffffc, 5'h08);
      xc(field_extract_zero_ext, 32'hc00,
         32'h0, 16'h0414, 5'h00, 32'hc, 5'h08);
      xc(field_extract_zero_ext, 32'h80000001,
         32'h0, 16'h0000, 5'h00, 32'h80000001, 5'h08);
      xc(field_insert, 32'hffffffff,
         32'h12, 16'h0808, 5'h00, 32'hff12ffff, 5'h08);
      xc(field_find_first_one, 32'h00100000,
         32'h0, 16'h0c04, 5'h00, 32'hb, 5'h00);
      xc(field_find_first_one, 32'h0,
         32'h0, 16'h041e, 5'h00, 32'h22, 5'h04);
      // Slow acceptance makes every answer stand for a few cycles
      m.slow = 3;
      xc(decimal_add_extend, 32'hab000045,
         32'h55, 16'h0, 5'h14, 32'hab000001, 5'h11);
      xc(decimal_sub_extend, 32'h10,
         32'h1, 16'h0, 5'h11, 32'h8, 5'h00);
      xc(decimal_sub_extend, 32'h0,
         32'h1, 16'h0, 5'h00, 32'h99, 5'h11);
      xc(decimal_negate_extend, 32'h25,
         32'h0, 16'h0, 5'h14, 32'h74, 5'h11);
      xc(decimal_a, 32'h0,
         32'h3132, 16'h0101, 5'h0a, 32'h23, 5'h0a);
      xc(decimal_unpack, 32'hdead0000,
         32'h47, 16'h3030, 5'h0a, 32'hdead3437, 5'h0a);
      m.slow = 0;
      m.wr(ADDR_RESULT, 32'h0, resp);
      chk("result bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
      m.rd(ADDR_RESULT, got, resp);
      chk("result kept", 32'hdead3437, got);
      wrap_up();
   end
endmodule : bit_field_bcd_execution_unit_tb
`default_nettype wire

// ### exec_checker.sv
// Handshake checker for the execution unit's register port
`timescale 1ns/1ps
`default_nettype none
module exec_checker
   import exec_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped early");
   a_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped early");
   a_aw_refused: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while answer pending");
   a_ar_refused: assert property (rvalid |-> !arready)
      else $error("read taken while answer pending");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_write_answer: assert property (awvalid && awready && wvalid && wready
      |=> !bvalid ##1 bvalid)
      else $error("write answer timing wrong");
   a_b_clears: assert property (bvalid && bready |=> !bvalid)
      else $error("write answer repeated");
   a_hole_read: assert property (arvalid && arready && araddr[7:5] != 3'h0
      |=> rresp == RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read not refused");
   a_map_read: assert property (arvalid && arready && araddr[7:5] == 3'h0
      |=> rresp == RESP_OKAY)
      else $error("mapped read refused");

   c_slow_write: cover property (bvalid && !bready);
   c_slow_read: cover property (rvalid && !rready);
   c_hole: cover property (rvalid && rresp == RESP_SLVERR);
endmodule : exec_checker

bind bit_field_bcd_execution_unit exec_checker u_chk
(
   .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
   .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
   .rdata, .rresp
);
`default_nettype wire

// ### exec_master.sv
// Register-port master standing in for the decoder and register file
`timescale 1ns/1ps
`default_nettype none
module exec_master
(
   input wire logic aclk,
   output logic awvalid,
   input wire logic awready,
   output logic [7:0] awaddr,
   output logic [2:0] awprot,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   input wire logic bvalid,
   output logic bready,
   input wire logic [1:0] bresp,
   output logic arvalid,
   input wire logic arready,
   output logic [7:0] araddr,
   output logic [2:0] arprot,
   input wire logic rvalid,
   output logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   // Cycles to wait before accepting an answer, to make it stand
   int slow = 0;

   initial
   begin
      awvalid = 1'b0;
      awaddr = 8'h0;
      awprot = 3'h0;
      wvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'hf;
      bready = 1'b0;
      arvalid = 1'b0;
      araddr = 8'h0;
      arprot = 3'h0;
      rready = 1'b0;
   end

   // Address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (awvalid && awready)
            aw_ok = 1'b1;
         if (wvalid && wready)
            w_ok = 1'b1;
         if (aw_ok)
            awvalid <= 1'b0;
         if (w_ok)
            wvalid <= 1'b0;
      end
      repeat (slow) @(posedge aclk);
      bready <= 1'b1;
      do
         @(posedge aclk);
      while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      arvalid <= 1'b1;
      araddr <= a;
      do
         @(posedge aclk);
      while (!arready);
      arvalid <= 1'b0;
      repeat (slow) @(posedge aclk);
      rready <= 1'b1;
      do
         @(posedge aclk);
      while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
endmodule : exec_master
`default_nettype wire

// ### exec_pkg.sv
// Constants and carrier types shared by the execution unit and its helpers
package exec_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_OP = 8'h00;
   localparam logic [7:0] ADDR_DST = 8'h04;
   localparam logic [7:0] ADDR_SRC = 8'h08;
   localparam logic [7:0] ADDR_IMM = 8'h0c;
   localparam logic [7:0] ADDR_FIELD = 8'h10;
   localparam logic [7:0] ADDR_GO = 8'h14;
   localparam logic [7:0] ADDR_RESULT = 8'h18;
   localparam logic [7:0] ADDR_FLAGS = 8'h1c;
   localparam int OP_CODE_LSB = 0;
   localparam int OP_MEM_BIT = 8;
   localparam int OP_IDX_REG_BIT = 9;
   localparam int FLD_OFS_LSB = 0;
   localparam int FLD_WID_LSB = 8;
   localparam int FLAG_C = 0;
   localparam int FLAG_V = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_N = 3;
   localparam int FLAG_X = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [5:0] FULL_WIDTH = 6'h20;
   localparam logic [4:0] DIGIT_MAX = 5'h09;
   localparam logic [4:0] DIGIT_ADJ = 5'h06;

   typedef enum logic [4:0] {
      single_bit_test,
      single_bit_test_set,
      single_bit_test_clear,
      single_bit_test_invert,
      field_test,
      field_test_set,
      field_test_clear,
      field_test_invert,
      field_extract_zero_ext,
      field_extract_sign_ext,
      field_insert,
      field_find_first_one,
      decimal_add_extend,
      decimal_sub_extend,
      decimal_negate_extend,
      decimal_a,
      decimal_unpack
   } op_t;

   typedef struct packed {
      op_t op;
      logic x;
      logic [7:0] dst;
      logic [7:0] src;
      logic [15:0] wide;
      logic [15:0] adj;
   } bcd_req_t;

   typedef struct packed {
      logic [15:0] value;
      logic carry;
   } bcd_resp_t;

   typedef struct packed {
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] op_reg;
      logic [31:0] dst_reg;
      logic [31:0] src_reg;
      logic [31:0] imm_reg;
      logic [31:0] fld_reg;
      logic [31:0] result_reg;
      logic [4:0] flags_reg;
      logic go;
   } state_t;

   localparam state_t STATE_RESET = '0;
endpackage : exec_pkg

// ### field_scan.sv
// Leading-zero count of a masked field image
`timescale 1ns/1ps
`default_nettype none
module field_scan
(
   input wire logic [31:0] bits,
   output logic [5:0] lead_zeros
);
   import exec_pkg::*;

   // Ascending loop: the highest set bit is assigned last and wins
   always_comb
   begin
      lead_zeros = FULL_WIDTH;
      for (int i = 0; i < 32; i++)
      begin
         if (bits[i])
         begin
            lead_zeros = 6'(31 - i);
         end
      end
   end
endmodule : field_scan
`default_nettype wire
